/* File: rxc_client_sink.sv */
`timescale 1ns/1ps
module rxc_client_sink (
  input wire logic i_clk,
  input wire logic i_valid,
  input wire logic i_end,
  output logic [15:0] o_frames
);
  initial o_frames = 16'h0000;
  // Markers are only believed while valid is high
  always @(posedge i_clk) begin
    if (i_valid && i_end) begin
      o_frames <= o_frames + 16'h0001;
    end
  end
endmodule // rxc_client_sink

/* File: rxc_crc_chk.sv */
`timescale 1ns/1ps
`include "rxc_defs.svh"
module rxc_crc_chk import rxc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  rxc_word_if.sink s,
  output logic o_crc_good
);

  rxc_crc_st_t st_r;
  rxc_crc_st_t st_nxt;
  logic [31:0] run;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] x;
    x = c ^ {24'h00_0000, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ `RXC_CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [63:0] d,
                                           input logic [3:0] n);
    logic [31:0] x;
    x = c;
    for (int k = 0; k < 8; k++) begin
      if (4'(k) < n) begin
        x = crc_byte(x, d[8*k +: 8]);
      end
    end
    return x;
  endfunction

  always_comb begin
    st_nxt = st_r;
    run = crc_word(s.start ? `RXC_CRC_INIT : st_r.crc, s.data, s.nbytes);
    if (s.valid) begin
      st_nxt.crc = run;
    end
    // Residue over data plus FCS is fixed when the frame is intact
    o_crc_good = (run == `RXC_CRC_RESIDUE);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r <= '{crc: `RXC_CRC_INIT};
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // rxc_crc_chk

/* File: rxc_defs.svh */
// Contract
// - All outputs synchronous to the receive clock
// - Earliest frame byte in most significant lane
// - Valid high exactly when the data word is meaningful
// - No valid gaps within a frame, FEC off
// - Idle cycles at alignment markers, FEC on
// - Start marker on the word with byte one
// - End marker on last data byte, FCS stripped
// - Pass-through keeps FCS, end on its last byte
// - Empty count gives unused lanes at end
// - Unused lanes are always the low-order bytes
// - Six-bit error vector, valid at end, top unused
// - Bit 4: payload shorter than advertised length
// - Bit 3: frame larger than configured maximum
// - Bit 2: frame shorter than 64 bytes
// - Bit 1: computed CRC differs from received
// - Bit 0: bad terminate; also sets bit 1
// - Status valid strobe marks a valid status word
// - Status word type flags, pause at bit 38
`ifndef RXC_DEFS_SVH
`define RXC_DEFS_SVH

`define RXC_MAC_CLK_KHZ 390625
`define RXC_WORD_BYTES 4'h8
`define RXC_FCS_BYTES 4'h4
`define RXC_HDR_FCS_BYTES 16'h0012
`define RXC_MIN_FRAME 16'h0040
`define RXC_LEN_TYPE_LIMIT 16'h0600
`define RXC_CTRL_TYPE 16'h8808
`define RXC_PAUSE_OPCODE 16'h0001
`define RXC_CRC_INIT 32'hFFFF_FFFF
`define RXC_CRC_POLY 32'hEDB8_8320
`define RXC_CRC_RESIDUE 32'hDEBB_20E3
`define RXC_BCAST_ADDR 48'hFFFF_FFFF_FFFF

`define RXC_ERR_MALFORMED 0
`define RXC_ERR_CRC 1
`define RXC_ERR_UNDERSIZE 2
`define RXC_ERR_OVERSIZE 3
`define RXC_ERR_PAYLOAD_LEN 4

`define RXC_ST_CONTROL 39
`define RXC_ST_PAUSE 38
`define RXC_ST_BCAST 37
`define RXC_ST_MCAST 36
`define RXC_ST_UCAST 35

`endif

/* File: rxc_frame_class.sv */
`timescale 1ns/1ps
`include "rxc_defs.svh"
module rxc_frame_class import rxc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  rxc_word_if.sink s,
  output logic o_ucast,
  output logic o_mcast,
  output logic o_bcast,
  output logic o_ctrl,
  output logic o_pause,
  output logic [15:0] o_len_type
);

  rxc_cls_st_t st_r;
  rxc_cls_st_t st_nxt;
  logic [15:0] lt;
  logic [15:0] opc;

  always_comb begin
    st_nxt = st_r;
    lt = {s.data[39:32], s.data[47:40]};
    opc = {s.data[55:48], s.data[63:56]};
    if (s.valid && s.start) begin
      // Destination address in wire bytes 0..5, group bit is bit 0 of byte 0
      st_nxt.bcast = (s.data[47:0] == `RXC_BCAST_ADDR);
      st_nxt.mcast = s.data[0] && (s.data[47:0] != `RXC_BCAST_ADDR);
      st_nxt.ucast = !s.data[0];
      st_nxt.ctrl = 1'b0;
      st_nxt.pause = 1'b0;
      st_nxt.len_type = 16'h0000;
      st_nxt.widx = 2'b01;
    end else if (s.valid && st_r.widx == 2'b01) begin
      st_nxt.len_type = lt;
      st_nxt.ctrl = (lt == `RXC_CTRL_TYPE);
      st_nxt.pause = (lt == `RXC_CTRL_TYPE) && (opc == `RXC_PAUSE_OPCODE);
      st_nxt.widx = 2'b10;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_ucast = st_r.ucast;
  assign o_mcast = st_r.mcast;
  assign o_bcast = st_r.bcast;
  assign o_ctrl = st_r.ctrl;
  assign o_pause = st_r.pause;
  assign o_len_type = st_r.len_type;

endmodule // rxc_frame_class

/* File: rxc_pkg.sv */
package rxc_pkg;

  typedef enum logic [1:0] {
    RXC_IDLE  = 2'b00,
    RXC_BODY  = 2'b01,
    RXC_FLUSH = 2'b10
  } rxc_state_t;

  typedef struct packed {
    logic [31:0] crc;
  } rxc_crc_st_t;

  typedef struct packed {
    logic [1:0] widx;
    logic ucast;
    logic mcast;
    logic bcast;
    logic ctrl;
    logic pause;
    logic [15:0] len_type;
  } rxc_cls_st_t;

  typedef struct packed {
    rxc_state_t fsm;
    logic [63:0] hold_data;
    logic hold_start;
    logic [3:0] hold_bytes;
    logic [15:0] byte_cnt;
    logic [5:0] fin_err;
    logic [39:0] fin_status;
    logic [63:0] out_data;
    logic out_valid;
    logic out_start;
    logic out_end;
    logic [2:0] out_empty;
    logic [5:0] out_err;
    logic out_sv;
    logic [39:0] out_status;
  } rxc_main_st_t;

endpackage

/* File: rxc_rx_client_port.sv */
`timescale 1ns/1ps
`include "rxc_defs.svh"
module rxc_rx_client_port import rxc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_pcs_ready,
  input wire logic i_reed_solomon_fec_option,
  input wire logic i_crc_pass_through,
  input wire logic [15:0] i_max_frame_size,
  input wire logic i_am_cycle,
  input wire logic i_in_valid,
  input wire logic i_in_start,
  input wire logic i_in_end,
  input wire logic [3:0] i_in_bytes,
  input wire logic i_in_bad_term,
  input wire logic [63:0] i_in_data,
  output logic [63:0] o_rx_client_data_word,
  output logic o_rx_client_valid,
  output logic o_rx_client_frame_start,
  output logic o_rx_client_frame_end,
  output logic [2:0] o_rx_client_empty_count,
  output logic [5:0] o_rx_client_error_vector,
  output logic o_rx_frame_status_valid,
  output logic [39:0] o_rx_frame_status_word
);

  rxc_main_st_t st_r;
  rxc_main_st_t st_nxt;

  rxc_word_if w ();

  logic crc_good;
  logic c_ucast;
  logic c_mcast;
  logic c_bcast;
  logic c_ctrl;
  logic c_pause;
  logic [15:0] c_len_type;

  logic am_gap;
  logic [3:0] bytes_in;
  logic [3:0] fcs_len;
  logic has_data;
  logic [3:0] data_bytes;
  logic [3:0] lack;
  logic [15:0] cnt_now;
  logic [15:0] lt_now;
  logic [15:0] payload;
  logic [5:0] err;
  logic [39:0] status;
  logic [63:0] flipped;
  logic hold_ok;

  // Wire order has byte 0 in the low lane; client order puts it on top
  function automatic logic [63:0] lane_flip(input logic [63:0] d);
    logic [63:0] r;
    r = '0;
    for (int k = 0; k < 8; k++) begin
      r[63-8*k -: 8] = d[8*k +: 8];
    end
    return r;
  endfunction

  // Keeps the top n lanes, clears the low-order ones
  function automatic logic [63:0] keep_lanes(input logic [63:0] d, input logic [3:0] n);
    logic [63:0] r;
    r = '0;
    for (int k = 0; k < 8; k++) begin
      if (4'(k) < n) begin
        r[63-8*k -: 8] = d[63-8*k -: 8];
      end
    end
    return r;
  endfunction

  function automatic rxc_main_st_t put(input rxc_main_st_t s, input logic [63:0] d,
                                       input logic sop, input logic eop,
                                       input logic [3:0] n, input logic [5:0] e,
                                       input logic [39:0] sw);
    rxc_main_st_t r;
    r = s;
    r.out_data = keep_lanes(d, n);
    r.out_valid = 1'b1;
    r.out_start = sop;
    r.out_end = eop;
    r.out_empty = eop ? 3'(`RXC_WORD_BYTES - n) : 3'h0;
    r.out_err = eop ? e : 6'h00;
    r.out_sv = eop;
    r.out_status = eop ? sw : 40'h00_0000_0000;
    return r;
  endfunction

  // FEC alignment-marker slots are idle even mid-frame
  assign am_gap = i_reed_solomon_fec_option && i_am_cycle;
  assign w.valid = i_in_valid && i_pcs_ready && !am_gap;
  assign w.start = i_in_start;
  assign w.last = i_in_end;
  assign w.data = i_in_data;
  assign w.nbytes = i_in_end ? i_in_bytes : `RXC_WORD_BYTES;

  rxc_crc_chk u_crc (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .s(w),
    .o_crc_good(crc_good)
  );

  rxc_frame_class u_cls (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .s(w),
    .o_ucast(c_ucast),
    .o_mcast(c_mcast),
    .o_bcast(c_bcast),
    .o_ctrl(c_ctrl),
    .o_pause(c_pause),
    .o_len_type(c_len_type)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.out_valid = 1'b0;
    st_nxt.out_start = 1'b0;
    st_nxt.out_end = 1'b0;
    st_nxt.out_empty = 3'h0;
    st_nxt.out_err = 6'h00;
    st_nxt.out_sv = 1'b0;
    st_nxt.out_status = 40'h00_0000_0000;

    bytes_in = w.nbytes;
    fcs_len = i_crc_pass_through ? 4'h0 : `RXC_FCS_BYTES;
    has_data = (bytes_in > fcs_len);
    data_bytes = bytes_in - fcs_len;
    lack = fcs_len - bytes_in;
    cnt_now = (i_in_start ? 16'h0000 : st_r.byte_cnt) + {12'h000, bytes_in};
    lt_now = c_len_type;
    flipped = lane_flip(i_in_data);
    hold_ok = (st_r.fsm == RXC_BODY) && !i_in_start;

    payload = (lt_now < `RXC_LEN_TYPE_LIMIT) ? lt_now :
              (cnt_now > `RXC_HDR_FCS_BYTES) ? cnt_now - `RXC_HDR_FCS_BYTES : 16'h0000;
    err = 6'h00;
    err[`RXC_ERR_MALFORMED] = i_in_bad_term;
    err[`RXC_ERR_CRC] = !crc_good || i_in_bad_term;
    err[`RXC_ERR_UNDERSIZE] = (cnt_now < `RXC_MIN_FRAME);
    err[`RXC_ERR_OVERSIZE] = (cnt_now > i_max_frame_size);
    err[`RXC_ERR_PAYLOAD_LEN] = (lt_now < `RXC_LEN_TYPE_LIMIT) &&
                                ({1'b0, cnt_now} < {1'b0, lt_now} + 17'h0_0012);
    status = 40'h00_0000_0000;
    status[`RXC_ST_CONTROL] = c_ctrl;
    status[`RXC_ST_PAUSE] = c_pause;
    status[`RXC_ST_BCAST] = c_bcast;
    status[`RXC_ST_MCAST] = c_mcast;
    status[`RXC_ST_UCAST] = c_ucast;
    status[31:16] = cnt_now;
    status[15:0] = payload;

    // Final word waits one cycle, not in a marker slot
    if (st_r.fsm == RXC_FLUSH && !am_gap) begin
      st_nxt = put(st_nxt, st_r.hold_data, st_r.hold_start, 1'b1, st_r.hold_bytes,
                   st_r.fin_err, st_r.fin_status);
      st_nxt.fsm = RXC_IDLE;
    end

    if (w.valid) begin
      if (!i_in_end) begin
        if (hold_ok) begin
          st_nxt = put(st_nxt, st_r.hold_data, st_r.hold_start, 1'b0, `RXC_WORD_BYTES,
                       6'h00, 40'h00_0000_0000);
        end
        st_nxt.hold_data = flipped;
        st_nxt.hold_start = i_in_start;
        st_nxt.hold_bytes = `RXC_WORD_BYTES;
        st_nxt.byte_cnt = cnt_now;
        st_nxt.fsm = RXC_BODY;
      end else if (has_data) begin
        if (hold_ok) begin
          st_nxt = put(st_nxt, st_r.hold_data, st_r.hold_start, 1'b0, `RXC_WORD_BYTES,
                       6'h00, 40'h00_0000_0000);
        end
        st_nxt.hold_data = flipped;
        st_nxt.hold_start = i_in_start;
        st_nxt.hold_bytes = data_bytes;
        st_nxt.byte_cnt = cnt_now;
        st_nxt.fin_err = err;
        st_nxt.fin_status = status;
        st_nxt.fsm = RXC_FLUSH;
      end else begin
        // Last word is all FCS: held word becomes the end of frame
        if (hold_ok) begin
          st_nxt = put(st_nxt, st_r.hold_data, st_r.hold_start, 1'b1,
                       `RXC_WORD_BYTES - lack, err, status);
        end
        st_nxt.byte_cnt = cnt_now;
        st_nxt.fsm = RXC_IDLE;
      end
    end

    // Nothing is delivered while the PCS is not ready
    if (!i_pcs_ready) begin
      st_nxt.fsm = RXC_IDLE;
      st_nxt.out_valid = 1'b0;
      st_nxt.out_start = 1'b0;
      st_nxt.out_end = 1'b0;
      st_nxt.out_sv = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rx_client_data_word = st_r.out_data;
  assign o_rx_client_valid = st_r.out_valid;
  assign o_rx_client_frame_start = st_r.out_start;
  assign o_rx_client_frame_end = st_r.out_end;
  assign o_rx_client_empty_count = st_r.out_empty;
  assign o_rx_client_error_vector = st_r.out_err;
  assign o_rx_frame_status_valid = st_r.out_sv;
  assign o_rx_frame_status_word = st_r.out_status;

endmodule // rxc_rx_client_port

/* File: rxc_rx_client_port_assertions.sv */
`timescale 1ns/1ps
module rxc_rx_client_port_assertions import rxc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_pcs_ready,
  input wire logic i_reed_solomon_fec_option,
  input wire logic [15:0] i_max_frame_size,
  input logic [63:0] o_rx_client_data_word,
  input logic o_rx_client_valid,
  input logic o_rx_client_frame_start,
  input logic o_rx_client_frame_end,
  input logic [2:0] o_rx_client_empty_count,
  input logic [5:0] o_rx_client_error_vector,
  input logic o_rx_frame_status_valid,
  input logic [39:0] o_rx_frame_status_word
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_open;
    o_rx_client_valid && !o_rx_client_frame_end && !i_reed_solomon_fec_option;
  endsequence
  sequence s_final;
    o_rx_frame_status_valid && o_rx_client_frame_end;
  endsequence
  a_no_gap: assert property (s_open |=> o_rx_client_valid) else $error("gap");
  a_start_valid: assert property (o_rx_client_frame_start |-> o_rx_client_valid)
    else $error("start without valid");
  a_end_valid: assert property (o_rx_client_frame_end |-> o_rx_client_valid)
    else $error("end without valid");
  a_empty_at_end: assert property (o_rx_client_empty_count != 0 |-> o_rx_client_frame_end)
    else $error("empty off end");
  a_low_lanes_zero: assert property (o_rx_client_frame_end |->
    (o_rx_client_data_word & ((64'h1 << (8 * o_rx_client_empty_count)) - 1)) == 0)
    else $error("low lanes not empty");
  a_err_top_zero: assert property (!o_rx_client_error_vector[5]) else $error("bit 5");
  a_err_at_end: assert property (o_rx_client_error_vector != 0 |-> o_rx_client_frame_end)
    else $error("error off end");
  a_malformed_crc: assert property (o_rx_client_error_vector[0] |-> o_rx_client_error_vector[1])
    else $error("malformed without crc");
  a_status_end: assert property (o_rx_frame_status_valid == o_rx_client_frame_end)
    else $error("status strobe");
  a_pause_ctrl: assert property (s_final ##0 o_rx_frame_status_word[38] |->
    o_rx_frame_status_word[39]) else $error("pause not control");
  a_undersize: assert property (s_final |->
    o_rx_client_error_vector[2] == (o_rx_frame_status_word[31:16] < 16'h0040))
    else $error("undersize");
  a_oversize: assert property (s_final |->
    o_rx_client_error_vector[3] == (o_rx_frame_status_word[31:16] > i_max_frame_size))
    else $error("oversize");
  a_reset_quiet: assert property ($past(i_sys_rst) |-> !o_rx_client_valid)
    else $error("valid after reset");
  a_ready_gate: assert property (!i_pcs_ready |=> !o_rx_client_valid)
    else $error("valid while pcs down");
endmodule // rxc_rx_client_port_assertions
bind rxc_rx_client_port rxc_rx_client_port_assertions u_chk (.*);

/* File: rxc_word_if.sv */
`timescale 1ns/1ps
interface rxc_word_if;
  logic valid;
  logic start;
  logic last;
  logic [63:0] data;
  logic [3:0] nbytes;
  modport src (output valid, output start, output last, output data, output nbytes);
  modport sink (input valid, input start, input last, input data, input nbytes);
endinterface

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench import rxc_pkg::*; ;
  typedef struct packed {
    logic [63:0] d; logic s; logic e; logic [2:0] em; logic [5:0] er; logic [39:0] st;
  } rxc_exp_t;
  logic i_clk = 0, i_sys_rst = 1, fec = 0, ptc = 0, am = 0, iv = 0, is = 0, ie = 0, ibt = 0;
  logic pr = 1;
  logic [3:0] inb = 0;
  logic [63:0] ind = 0;
  logic [15:0] maxf = 16'h0050;
  logic [63:0] od;
  logic ov, os, oe, osv;
  logic [2:0] oem;
  logic [5:0] oer;
  logic [39:0] ost;
  logic [15:0] frames;
  logic [7:0] fb [0:127];
  logic [15:0] tfs [3] = '{16'h0800, 16'h8808, 16'h0040};
  rxc_exp_t q [$];
  rxc_exp_t y;
  int fail_count = 0, checks = 0, cyc = 0, sent = 0;
  always #10 i_clk = ~i_clk;
  rxc_rx_client_port dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pcs_ready(pr),
    .i_reed_solomon_fec_option(fec), .i_crc_pass_through(ptc), .i_max_frame_size(maxf),
    .i_am_cycle(am), .i_in_valid(iv), .i_in_start(is), .i_in_end(ie), .i_in_bytes(inb),
    .i_in_bad_term(ibt), .i_in_data(ind), .o_rx_client_data_word(od), .o_rx_client_valid(ov),
    .o_rx_client_frame_start(os), .o_rx_client_frame_end(oe), .o_rx_client_empty_count(oem),
    .o_rx_client_error_vector(oer), .o_rx_frame_status_valid(osv),
    .o_rx_frame_status_word(ost));
  rxc_client_sink u_sink (.i_clk(i_clk), .i_valid(ov), .i_end(oe), .o_frames(frames));
  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic [31:0] crc8(logic [31:0] c, logic [7:0] b);
    c ^= b;
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
    return c;
  endfunction
  task send(input int n, input logic [15:0] tf, input logic bc, input logic bt);
    logic [31:0] c;
    logic [63:0] dw;
    rxc_exp_t x;
    int m, w, i;
    logic a;
    logic bca;
    c = 32'hFFFF_FFFF;
    for (i = 0; i < n; i++) fb[i] = 8'($urandom);
    {fb[12], fb[13], fb[14], fb[15]} = {tf, 16'h0001};
    // Some frames go to the broadcast address
    if (n % 8 == 4) for (i = 0; i < 6; i++) fb[i] = 8'hFF;
    bca = ({fb[0], fb[1], fb[2], fb[3], fb[4], fb[5]} == 48'hFFFF_FFFF_FFFF);
    for (i = 0; i < n - 4; i++) c = crc8(c, fb[i]);
    c = ~c;
    for (i = 0; i < 4; i++) fb[n-4+i] = c[8*i+:8];
    if (bc) fb[n-1] = ~fb[n-1];
    m = ptc ? n : n - 4;
    for (w = 0; w * 8 < m; w++) begin
      x = '0;
      x.s = (w == 0);
      x.e = (w * 8 + 8 >= m);
      for (i = 0; i < 8; i++) if (w * 8 + i < m) x.d[63-8*i-:8] = fb[w*8+i];
      if (x.e) begin
        x.em = 3'(w * 8 + 8 - m);
        x.er = {1'b0, tf < 16'h0600 && n < tf + 18, n > maxf, n < 64, bc | bt, bt};
        x.st = {tf == 16'h8808, tf == 16'h8808, bca, fb[0][0] & !bca, !fb[0][0], 3'h0, 16'(n),
                tf < 16'h0600 ? tf : 16'(n - 18)};
      end
      q.push_back(x);
    end
    i = 0;
    while (i * 8 < n) begin
      @(posedge i_clk);
      a = ($urandom % 4 == 0);
      for (w = 0; w < 8; w++) dw[8*w+:8] = (i * 8 + w < n) ? fb[i*8+w] : 8'h00;
      am <= a;
      iv <= 1'b1;
      is <= (i == 0);
      ie <= (i * 8 + 8 >= n);
      inb <= (i * 8 + 8 >= n) ? 4'(n - i * 8) : 4'h8;
      ibt <= bt && (i * 8 + 8 >= n);
      ind <= dw;
      if (!(a && fec)) i++;
    end
  endtask
  always @(negedge i_clk) begin
    if (ov === 1'b1) begin
      if (q.size() == 0) chk("extra word", 64'h1, 64'h0);
      else begin
        y = q.pop_front();
        chk("data", od, y.d);
        chk("start", os, y.s);
        chk("end", oe, y.e);
        chk("empty", oem, y.em);
        chk("error", oer, y.er);
        chk("status valid", osv, y.e);
        chk("status", ost, y.st);
      end
    end
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(87));
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 0;
    for (int md = 0; md < 4; md++) begin
      @(posedge i_clk);
      fec <= md[0];
      ptc <= md[1];
      maxf <= 16'h0040 + 16'($urandom % 48);
      // Let the new mode settle before expectations read it
      @(posedge i_clk);
      for (int k = 0; k < 12; k++) begin
        send(k < 8 ? 57 + k : 20 + $urandom % 80, tfs[$urandom % 3], k == 9 || k == 11, k == 10);
        sent++;
      end
      @(posedge i_clk);
      iv <= 0;
      am <= 0;
      // Words offered while the PCS is down must not come out
      @(posedge i_clk);
      pr <= 0;
      iv <= 1;
      is <= 1;
      repeat (3) @(posedge i_clk);
      iv <= 0;
      pr <= 1;
      repeat (12) @(posedge i_clk);
    end
    chk("pending words", q.size(), 0);
    chk("frames", frames, sent);
    give_verdict();
  end
endmodule // testbench
